/* hw/esm_pkg.sv */
package esm_pkg;

  // Bus cycle phases, Gray coded along idle-setup-strobe-off
  typedef enum logic [1:0] {
    ESM_IDLE   = 2'h0,
    ESM_SETUP  = 2'h1,
    ESM_STROBE = 2'h3,
    ESM_OFF    = 2'h2
  } esm_state_t;

  // Boot strap codes on the boot region select pair
  localparam logic [1:0] BOOT_RSVD  = 2'h0;
  localparam logic [1:0] BOOT_STACK = 2'h1;
  localparam logic [1:0] BOOT_CS1   = 2'h2;
  localparam logic [1:0] BOOT_CS0   = 2'h3;

  // Phase counter width, enough for a 32 cycle access
  localparam int CNT_W = 6;

  // First region: short mode 3..8 with one set-up cycle
  localparam logic [5:0] CS0_SHORT_BASE  = 6'h03;
  localparam logic [5:0] CS0_SHORT_SETUP = 6'h01;
  // First region: long mode 6..16 step 2 with two set-up cycles
  localparam logic [5:0] CS0_LONG_BASE   = 6'h06;
  localparam logic [5:0] CS0_LONG_SETUP  = 6'h02;
  localparam logic [2:0] CS0_SEL_MAX     = 3'h5;

  // Second region: 2,4,8,16,32 cycles, one of them set-up
  localparam logic [5:0] CS1_BASE        = 6'h02;
  localparam logic [2:0] CS1_SEL_MAX     = 3'h4;
  // Selection code of the 16 cycle access, the only one with wait
  localparam logic [2:0] CS1_WAIT_SEL    = 3'h3;
  localparam logic [5:0] WAIT_STEP       = 6'h10;

  // Page size of page-mode flash in byte address bits
  localparam int PAGE_LSB = 3;

endpackage

/* hw/esm_tmr_if.sv */
`timescale 1ns/1ps
// Phase timer link between the sequencer and its down counter
interface esm_tmr_if;
  logic                    load;
  logic [esm_pkg::CNT_W-1:0] load_val;
  logic                    done;

  modport owner (input load, input load_val, output done);
  modport user  (output load, output load_val, input done);
endinterface

/* hw/esm_cnt.sv */
`timescale 1ns/1ps
// Down counter: a load of N keeps done low for N cycles
module esm_cnt #(
  parameter int W = esm_pkg::CNT_W
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  esm_tmr_if.owner  tmr
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Load values arrive over the timer link at its fixed width
  if (W != esm_pkg::CNT_W) begin : g_bad_w
    $error("esm_cnt: W must match the timer link width");
  end

  // Next count
  always_comb begin
    cnt_d = cnt_q;
    if (tmr.load) begin
      cnt_d = tmr.load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // Count register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tmr.done = (cnt_q == '0);

endmodule

/* hw/esm_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Boot region chosen from two strap pins
// - Boot bank width strap: low 8, high 16
// - First region single bank, byte lanes, strobe
// - First region access 3..8 or 6..16 cycles
// - Data-off hold of 1 to 4 cycles
// - First region SRAM, flash, optional page mode
// - Second region access 2,4,8,16,32 cycles
// - Wait only at 16 cycles, adds 16 each
// - Early write data: none, or address set-up minus one
// - 16-bit bus leaves address bit zero unused
// - Gated output enable is select AND read strobe
module esm_ctrl (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Straps
  input  wire logic [1:0]  boot_region_select_in,
  input  wire logic        boot_bank_width_pin_in,
  output logic      [1:0]  boot_region_out,
  output logic             boot_width16_out,
  // Configuration
  input  wire logic        cs0_width16_in,
  input  wire logic        cs0_two_setup_in,
  input  wire logic [2:0]  cs0_access_sel_in,
  input  wire logic        cs0_page_mode_in,
  input  wire logic        cs1_width16_in,
  input  wire logic [2:0]  cs1_access_sel_in,
  input  wire logic [1:0]  cs1_addr_setup_sel_in,
  input  wire logic        write_timing_kind_in,
  input  wire logic [1:0]  data_off_sel_in,
  // Request and answer
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        req_boot_in,
  input  wire logic        req_write_in,
  input  wire logic [20:0] req_addr_in,
  input  wire logic [1:0]  req_be_in,
  input  wire logic [15:0] req_wdata_in,
  output logic             rsp_valid_out,
  output logic             rsp_err_out,
  output logic      [15:0] rsp_rdata_out,
  // External bus
  output logic      [19:0] ext_addr_out,
  output logic      [15:0] ext_data_out,
  output logic             ext_data_oe_out,
  input  wire logic [15:0] ext_data_in,
  output logic      [1:0]  ext_chip_select_n_out,
  output logic             read_strobe_n_out,
  output logic             write_strobe_n_out,
  output logic      [1:0]  byte_lane_select_n_out,
  output logic      [1:0]  gated_output_enable_n_out,
  input  wire logic        ext_wait_n_in
);

  //////////////////////////////////////////////////////////////////////////
  // Strap and wait synchronisers, strap capture

  logic [2:0] strap_m_q;
  logic [2:0] strap_s_q;
  logic       wait_m_q;
  logic       wait_s_q;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic       strap_ok_q;
  logic       strap_ok_d;
  logic [1:0] boot_reg_q;
  logic [1:0] boot_reg_d;
  logic       boot_w16_q;
  logic       boot_w16_d;

  // Strap and wait pin levels pass two flops before anything reads them
  always_ff @(posedge clk_in) begin
    strap_m_q <= {boot_bank_width_pin_in, boot_region_select_in};
    strap_s_q <= strap_m_q;
    wait_m_q  <= ext_wait_n_in;
    wait_s_q  <= wait_m_q;
  end

  // Straps latch once the synchroniser has refilled after reset
  always_comb begin
    settle_d   = settle_q;
    strap_ok_d = strap_ok_q;
    boot_reg_d = boot_reg_q;
    boot_w16_d = boot_w16_q;
    if (!strap_ok_q) begin
      if (settle_q != 2'h3) begin
        settle_d = settle_q + 2'h1;
      end else begin
        strap_ok_d = 1'b1;
        boot_reg_d = strap_s_q[1:0];
        boot_w16_d = strap_s_q[2];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      settle_q   <= 2'h0;
      strap_ok_q <= 1'b0;
      boot_reg_q <= esm_pkg::BOOT_RSVD;
      boot_w16_q <= 1'b0;
    end else begin
      settle_q   <= settle_d;
      strap_ok_q <= strap_ok_d;
      boot_reg_q <= boot_reg_d;
      boot_w16_q <= boot_w16_d;
    end
  end

  assign boot_region_out  = boot_reg_q;
  assign boot_width16_out = boot_w16_q;

  //////////////////////////////////////////////////////////////////////////
  // Phase timer

  esm_tmr_if tmr ();

  esm_cnt #(.W(esm_pkg::CNT_W)) u_cnt (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tmr        (tmr)
  );

  //////////////////////////////////////////////////////////////////////////
  // Access sequencer

  esm_pkg::esm_state_t st_q, st_d;
  logic        reg_q, reg_d;        // Region of the access
  logic        w16_q, w16_d;        // Bus width of the access
  logic        wr_q, wr_d;
  logic [19:0] addr_q, addr_d;
  logic [1:0]  be_q, be_d;
  logic [15:0] wdata_q, wdata_d;
  logic        hi_q, hi_d;          // Current 8-bit beat is the high byte
  logic        more_q, more_d;      // A second 8-bit beat follows
  logic [15:0] rdata_q, rdata_d;
  logic        rsp_q, rsp_d;
  logic        err_q, err_d;
  localparam int PAGE_W = esm_pkg::PAGE_LSB;
  logic [19:PAGE_W] page_q, page_d;
  logic        page_ok_q, page_ok_d;
  logic        wr_early_q, wr_early_d;
  logic        setup_old_q, setup_old_d; // Set-up has run a cycle already

  logic [5:0]  setup_len;
  logic [5:0]  strobe_len;
  logic [5:0]  off_len;
  logic        page_hit;
  logic        accept;

  assign req_ready_out = (st_q == esm_pkg::ESM_IDLE) && strap_ok_q;
  assign accept        = req_valid_in && req_ready_out;

  // Phase lengths of the region held in reg_d
  always_comb begin
    if (!reg_d) begin
      if (cs0_two_setup_in) begin
        setup_len  = esm_pkg::CS0_LONG_SETUP;
        strobe_len = esm_pkg::CS0_LONG_BASE
                   + {2'h0, cs0_access_sel_in, 1'b0}
                   - esm_pkg::CS0_LONG_SETUP;
      end else begin
        setup_len  = esm_pkg::CS0_SHORT_SETUP;
        strobe_len = esm_pkg::CS0_SHORT_BASE
                   + {3'h0, cs0_access_sel_in}
                   - esm_pkg::CS0_SHORT_SETUP;
      end
    end else begin
      // Address set-up replaces the single set-up cycle
      setup_len  = {4'h0, cs1_addr_setup_sel_in} + 6'h01;
      strobe_len = (esm_pkg::CS1_BASE << cs1_access_sel_in) - 6'h01;
    end
    off_len = {4'h0, data_off_sel_in} + 6'h01;
  end

  // Page-mode flash: a read in the open page skips set-up
  assign page_hit = cs0_page_mode_in && page_ok_q && !req_write_in
                 && !reg_d && (req_addr_in[19:PAGE_W] == page_q);

  // Sequencer next state
  always_comb begin
    st_d      = st_q;
    reg_d     = reg_q;
    w16_d     = w16_q;
    wr_d      = wr_q;
    addr_d    = addr_q;
    be_d      = be_q;
    wdata_d   = wdata_q;
    hi_d      = hi_q;
    more_d    = more_q;
    rdata_d   = rdata_q;
    rsp_d     = 1'b0;
    err_d     = 1'b0;
    page_d    = page_q;
    page_ok_d = page_ok_q;
    wr_early_d = wr_early_q;
    setup_old_d = (st_q == esm_pkg::ESM_SETUP);
    tmr.load     = 1'b0;
    tmr.load_val = '0;
    if (accept) begin
      reg_d = req_addr_in[20];
      w16_d = req_addr_in[20] ? cs1_width16_in : cs0_width16_in;
      if (req_boot_in) begin
        reg_d = (boot_reg_q == esm_pkg::BOOT_CS1);
        w16_d = boot_w16_q;
      end
    end
    unique case (st_q)
      esm_pkg::ESM_IDLE: begin
        if (accept && req_boot_in
            && (boot_reg_q == esm_pkg::BOOT_RSVD
             || boot_reg_q == esm_pkg::BOOT_STACK)) begin
          rsp_d = 1'b1;                  // Not an external region
          err_d = 1'b1;
        end else if (accept) begin
          wr_d    = req_write_in;
          addr_d  = req_addr_in[19:0];
          be_d    = req_be_in;
          wdata_d = req_wdata_in;
          more_d  = !w16_d && (req_be_in == 2'h3);
          hi_d    = !w16_d && (req_be_in == 2'h2);
          rdata_d = '0;
          wr_early_d = reg_d && write_timing_kind_in;
          tmr.load = 1'b1;
          if (page_hit) begin
            st_d         = esm_pkg::ESM_STROBE;
            tmr.load_val = strobe_len - 6'h01;
          end else begin
            st_d         = esm_pkg::ESM_SETUP;
            tmr.load_val = setup_len - 6'h01;
          end
        end
      end
      esm_pkg::ESM_SETUP: begin
        if (tmr.done) begin
          st_d         = esm_pkg::ESM_STROBE;
          tmr.load     = 1'b1;
          tmr.load_val = strobe_len - 6'h01;
        end
      end
      esm_pkg::ESM_STROBE: begin
        if (tmr.done && reg_q && !wait_s_q
            && cs1_access_sel_in == esm_pkg::CS1_WAIT_SEL) begin
          tmr.load     = 1'b1;
          tmr.load_val = esm_pkg::WAIT_STEP - 6'h01;
        end else if (tmr.done) begin
          // Data is sampled on the last strobe cycle; the timing
          // settings, not a synchroniser, make it stable here
          if (w16_q) begin
            rdata_d = ext_data_in;
          end else if (hi_q) begin
            rdata_d[15:8] = ext_data_in[7:0];
          end else begin
            rdata_d[7:0] = ext_data_in[7:0];
          end
          page_d    = addr_q[19:PAGE_W];
          page_ok_d = !wr_q && !reg_q;
          st_d         = esm_pkg::ESM_OFF;
          tmr.load     = 1'b1;
          tmr.load_val = off_len - 6'h01;
          rsp_d = !more_q;
        end
      end
      esm_pkg::ESM_OFF: begin
        if (tmr.done && more_q) begin
          more_d       = 1'b0;                      // Second byte beat
          hi_d         = 1'b1;
          st_d         = esm_pkg::ESM_SETUP;
          tmr.load     = 1'b1;
          tmr.load_val = setup_len - 6'h01;
        end else if (tmr.done) begin
          st_d = esm_pkg::ESM_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q      <= esm_pkg::ESM_IDLE;
      reg_q     <= 1'b0;
      w16_q     <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= '0;
      be_q      <= 2'h0;
      wdata_q   <= '0;
      hi_q      <= 1'b0;
      more_q    <= 1'b0;
      rdata_q   <= '0;
      rsp_q     <= 1'b0;
      err_q     <= 1'b0;
      page_q    <= '0;
      page_ok_q <= 1'b0;
      wr_early_q <= 1'b0;
      setup_old_q <= 1'h0;
    end else begin
      st_q      <= st_d;
      reg_q     <= reg_d;
      w16_q     <= w16_d;
      wr_q      <= wr_d;
      addr_q    <= addr_d;
      be_q      <= be_d;
      wdata_q   <= wdata_d;
      hi_q      <= hi_d;
      more_q    <= more_d;
      rdata_q   <= rdata_d;
      rsp_q     <= rsp_d;
      err_q     <= err_d;
      page_q    <= page_d;
      page_ok_q <= page_ok_d;
      wr_early_q <= wr_early_d;
      setup_old_q <= setup_old_d;
    end
  end

  assign rsp_valid_out = rsp_q;
  assign rsp_err_out   = err_q;
  assign rsp_rdata_out = rdata_q;

  //////////////////////////////////////////////////////////////////////////
  // Pin decode from registered state only, so strobes cannot glitch

  logic active;
  logic strobe;
  logic cs1_wd_on;

  assign active = (st_q == esm_pkg::ESM_SETUP)
               || (st_q == esm_pkg::ESM_STROBE);
  assign strobe = (st_q == esm_pkg::ESM_STROBE);
  // Early write data: every set-up cycle but the first, so the data
  // leads the strobe by one cycle less than the address does
  assign cs1_wd_on = wr_early_q && (st_q == esm_pkg::ESM_SETUP)
      && setup_old_q;

  // Word address from bit one on a 16-bit bus
  assign ext_addr_out = w16_q ? {addr_q[19:1], 1'b0}
                              : {addr_q[19:1], hi_q | addr_q[0]};
  assign ext_data_out = (w16_q || !hi_q) ? wdata_q
                                         : {wdata_q[15:8], wdata_q[15:8]};
  // Bus released in off time and idle
  assign ext_data_oe_out = wr_q && (strobe || cs1_wd_on
                         || (active && !reg_q));

  // Active-low controls, all high outside an access
  assign ext_chip_select_n_out = {!(active && reg_q), !(active && !reg_q)};
  assign read_strobe_n_out  = !(strobe && !wr_q);
  assign write_strobe_n_out = !(strobe && wr_q);
  assign byte_lane_select_n_out = !active ? 2'h3
      : w16_q ? ~be_q : (hi_q ? 2'h1 : 2'h2);
  // Low only while both select and read strobe are low
  assign gated_output_enable_n_out = ext_chip_select_n_out
                                   | {2{read_strobe_n_out}};

endmodule

/* tb/esm_ctrl_properties.sv */
`timescale 1ns/1ps
module esm_ctrl_properties (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [1:0]  boot_region_out,
  input wire logic        cs0_width16_in,
  input wire logic        cs0_two_setup_in,
  input wire logic [2:0]  cs0_access_sel_in,
  input wire logic        cs0_page_mode_in,
  input wire logic        cs1_width16_in,
  input wire logic [2:0]  cs1_access_sel_in,
  input wire logic [1:0]  cs1_addr_setup_sel_in,
  input wire logic        write_timing_kind_in,
  input wire logic [1:0]  data_off_sel_in,
  input wire logic        req_valid_in,
  input wire logic        req_ready_out,
  input wire logic        req_boot_in,
  input wire logic        req_write_in,
  input wire logic [20:0] req_addr_in,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_err_out,
  input wire logic        ext_data_oe_out,
  input wire logic [1:0]  ext_chip_select_n_out,
  input wire logic        read_strobe_n_out,
  input wire logic        write_strobe_n_out,
  input wire logic [1:0]  gated_output_enable_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  //////////////////////////////////////////////////////////////////////////
  logic       acc;
  logic       cs1;
  logic       trk_q, trk_d;
  logic [6:0] cnt_q, cnt_d, exp_q, exp_d, len;
  assign acc = req_valid_in && req_ready_out && !req_boot_in;
  assign cs1 = req_addr_in[20];
  // Expected answer delay; page mode, 8-bit buses and the wait-capable code skip tracking
  always_comb begin
    len = 7'(cs0_access_sel_in) + 7'h04;
    if (cs0_two_setup_in)
      len = 7'(cs0_access_sel_in) * 7'h02 + 7'h07;
    if (cs1)
      len = (7'h02 << cs1_access_sel_in) + 7'(cs1_addr_setup_sel_in) + 7'h01;
    cnt_d = cnt_q + 7'h01;
    exp_d = exp_q;
    trk_d = trk_q && !rsp_valid_out;
    if (acc) begin
      cnt_d = 7'h01;
      exp_d = len;
      trk_d = cs1 ? cs1_width16_in && cs1_access_sel_in != 3'h3
                  : cs0_width16_in && !cs0_page_mode_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= 7'h00;
      exp_q <= 7'h00;
      trk_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
      trk_q <= trk_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  AST_LEN: assert property (rsp_valid_out && trk_q |-> cnt_q == exp_q)
    else $error("answer delay differs from access time");
  AST_OE_AND: assert property (gated_output_enable_n_out ==
      (ext_chip_select_n_out | {2{read_strobe_n_out}}))
    else $error("gated output enable is not select and read");
  AST_IDLE: assert property (req_ready_out |-> ext_chip_select_n_out == 2'h3
      && read_strobe_n_out && write_strobe_n_out && !ext_data_oe_out)
    else $error("strobe active while idle");
  AST_OFF4: assert property (rsp_valid_out && !rsp_err_out &&
      data_off_sel_in == 2'h3 |->
      (!req_ready_out && !ext_data_oe_out)[*4] ##1 req_ready_out)
    else $error("data off time wrong");
  AST_TWO_SETUP: assert property (acc && !cs1 && cs0_two_setup_in &&
      !req_write_in && !cs0_page_mode_in |-> ##1
      (ext_chip_select_n_out == 2'h2 && read_strobe_n_out)[*2]
      ##1 !read_strobe_n_out)
    else $error("first region set-up is not two cycles");
  AST_ASETUP: assert property (acc && cs1 && !req_write_in &&
      cs1_addr_setup_sel_in == 2'h3 |-> ##1
      (ext_chip_select_n_out == 2'h1 && read_strobe_n_out)[*4]
      ##1 !read_strobe_n_out)
    else $error("address set-up is not four cycles");
  AST_WDATA: assert property (acc && cs1 && req_write_in &&
      write_timing_kind_in && cs1_addr_setup_sel_in == 2'h2 |-> ##1
      !ext_data_oe_out ##1 (ext_data_oe_out && write_strobe_n_out)[*2]
      ##1 !write_strobe_n_out)
    else $error("write data set-up wrong");
  AST_BOOT_ERR: assert property (req_valid_in && req_ready_out &&
      req_boot_in && !boot_region_out[1] |-> ##1 rsp_valid_out && rsp_err_out)
    else $error("boot to unusable region not refused");
  COV_WAIT: cover property (acc && cs1 && cs1_access_sel_in == 3'h3);
  COV_PAGE: cover property (acc && cs0_page_mode_in && !cs1);
  COV_ERR: cover property (rsp_valid_out && rsp_err_out);
endmodule
bind esm_ctrl esm_ctrl_properties u_props (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .boot_region_out(boot_region_out), .cs0_width16_in(cs0_width16_in),
  .cs0_two_setup_in(cs0_two_setup_in), .cs0_access_sel_in(cs0_access_sel_in),
  .cs0_page_mode_in(cs0_page_mode_in), .cs1_width16_in(cs1_width16_in),
  .cs1_access_sel_in(cs1_access_sel_in),
  .cs1_addr_setup_sel_in(cs1_addr_setup_sel_in),
  .write_timing_kind_in(write_timing_kind_in),
  .data_off_sel_in(data_off_sel_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .req_boot_in(req_boot_in),
  .req_write_in(req_write_in), .req_addr_in(req_addr_in),
  .rsp_valid_out(rsp_valid_out), .rsp_err_out(rsp_err_out),
  .ext_data_oe_out(ext_data_oe_out),
  .ext_chip_select_n_out(ext_chip_select_n_out),
  .read_strobe_n_out(read_strobe_n_out),
  .write_strobe_n_out(write_strobe_n_out),
  .gated_output_enable_n_out(gated_output_enable_n_out));

/* tb/esm_mem_model.sv */
`timescale 1ns/1ps
module esm_mem_model (
  input  wire logic        clk_in,
  input  wire logic [19:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [1:0]  cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [1:0]  bs_n_in,
  input  wire logic [1:0]  width16_in,
  input  wire logic [5:0]  wait_len_in,
  output logic      [15:0] rdata_out,
  output logic             wait_n_out
);
  logic [7:0]  mem [0:511];
  logic [15:0] last_q = 16'h0000;
  logic [5:0]  wcnt_q = 6'h00;
  logic        stb_q = 1'h0;
  logic        rg, on;
  logic [8:0]  lo, hi;
  assign rg = !cs_n_in[1];
  assign on = cs_n_in != 2'h3;
  // Word devices ignore address bit zero, byte devices use it
  assign lo = {rg, addr_in[7:1], addr_in[0] & !width16_in[rg]};
  assign hi = {lo[8:1], 1'h1};
  assign wait_n_out = wcnt_q == 6'h00;
  // Fast part answers at once; off the bus the lines toggle every cycle
  always_comb begin
    rdata_out = ~last_q;
    if (on && !rd_n_in)
      rdata_out = width16_in[rg] ? {mem[hi], mem[lo]}
                                 : {~last_q[15:8], mem[lo]};
  end
  // Byte lanes gate writes to word devices; wait held low a set time from a second-region strobe start
  always @(posedge clk_in) begin
    last_q <= rdata_out;
    stb_q <= on && !(rd_n_in && wr_n_in);
    if (on && !wr_n_in && (!width16_in[rg] || !bs_n_in[0]))
      mem[lo] <= wdata_in[7:0];
    if (on && !wr_n_in && width16_in[rg] && !bs_n_in[1])
      mem[hi] <= wdata_in[15:8];
    if (rg && on && !(rd_n_in && wr_n_in) && !stb_q)
      wcnt_q <= wait_len_in;
    else if (wcnt_q != 6'h00)
      wcnt_q <= wcnt_q - 6'h01;
  end
endmodule

/* tb/test_ext_static_memory_bus.sv */
`timescale 1ns/1ps
module test_ext_static_memory_bus;
  logic        clk, rst, bwp, boot_w16, cs0_w16, cs0_two, cs0_page;
  logic        cs1_w16, wtk, valid, ready, rboot, rwr, rsp_v, rsp_e;
  logic        eoe, rd_n, wr_n, wait_n, got_er;
  logic [1:0]  strap, boot_region, cs1_as, off_sel, rbe, ecs_n, bs_n, goe_n;
  logic [2:0]  cs0_sel, cs1_sel;
  logic [5:0]  wait_len;
  logic [15:0] rwd, rsp_rd, edo, edi, got_rd;
  logic [19:0] ea;
  logic [20:0] raddr;
  int          failures = 0, checks = 0, cyc = 0, got_n, got_off, i;
  esm_ctrl DUT (
    .clk_in(clk), .sys_rst_in(rst), .boot_region_select_in(strap),
    .boot_bank_width_pin_in(bwp), .boot_region_out(boot_region),
    .boot_width16_out(boot_w16), .cs0_width16_in(cs0_w16),
    .cs0_two_setup_in(cs0_two), .cs0_access_sel_in(cs0_sel),
    .cs0_page_mode_in(cs0_page), .cs1_width16_in(cs1_w16),
    .cs1_access_sel_in(cs1_sel), .cs1_addr_setup_sel_in(cs1_as),
    .write_timing_kind_in(wtk), .data_off_sel_in(off_sel),
    .req_valid_in(valid), .req_ready_out(ready), .req_boot_in(rboot),
    .req_write_in(rwr), .req_addr_in(raddr), .req_be_in(rbe),
    .req_wdata_in(rwd), .rsp_valid_out(rsp_v), .rsp_err_out(rsp_e),
    .rsp_rdata_out(rsp_rd), .ext_addr_out(ea), .ext_data_out(edo),
    .ext_data_oe_out(eoe), .ext_data_in(edi), .ext_chip_select_n_out(ecs_n),
    .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
    .byte_lane_select_n_out(bs_n), .gated_output_enable_n_out(goe_n),
    .ext_wait_n_in(wait_n));
  esm_mem_model u_mem (
    .clk_in(clk), .addr_in(ea), .wdata_in(edo), .cs_n_in(ecs_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .bs_n_in(bs_n),
    .width16_in({cs1_w16, cs0_w16}), .wait_len_in(wait_len),
    .rdata_out(edi), .wait_n_out(wait_n));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results;
    end
  end
  task automatic chk_d(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // One access: delay to the answer and the off time after it are counted
  task automatic acc(input logic b, input logic w, input logic [20:0] a,
                     input logic [1:0] be, input logic [15:0] wd);
    rboot = b;
    rwr = w;
    raddr = a;
    rbe = be;
    rwd = wd;
    valid = 1'h1;
    got_n = 0;
    while (ready !== 1'h1 && got_n < 100) begin
      @(negedge clk);
      got_n++;
    end
    @(negedge clk);
    valid = 1'h0;
    got_n = 1;
    while (rsp_v !== 1'h1 && got_n < 200) begin
      @(negedge clk);
      got_n++;
    end
    got_rd = rsp_rd;
    got_er = rsp_e;
    got_off = 0;
    do begin
      @(negedge clk);
      got_off++;
    end while (ready !== 1'h1 && got_off < 20);
  endtask
  task automatic boot(input logic [1:0] s, input logic p);
    strap = s;
    bwp = p;
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    repeat (6) @(negedge clk);
    chk_d({14'h0000, boot_region}, {14'h0000, s});
    chk_d({15'h0000, boot_w16}, {15'h0000, p});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    // Slowest timings first, as software does straight after reset
    cs0_two = 1'h1;
    cs0_sel = 3'h5;
    cs1_sel = 3'h4;
    cs1_as = 2'h3;
    off_sel = 2'h3;
    {cs0_w16, cs1_w16, cs0_page, wtk, valid, rboot, rwr} = 7'h60;
    {raddr, rbe, rwd, wait_len} = 45'h0000000000000;
    boot(2'h3, 1'h1);
    acc(1'h1, 1'h1, 21'h000010, 2'h3, 16'hBEEF);
    chk_n(got_n, 17);
    chk_n(got_off, 4);
    acc(1'h1, 1'h0, 21'h000010, 2'h3, 16'h0000);
    chk_d(got_rd, 16'hBEEF);
    $display("test boot done");
    for (i = 0; i < 12; i++) begin
      cs0_two = i >= 6;
      cs0_sel = 3'(i % 6);
      off_sel = 2'(i % 4);
      acc(1'h0, 1'h1, 21'(2 * i), 2'h3, 16'(16'h1000 + i));
      chk_n(got_n, i < 6 ? i + 4 : 2 * i - 5);
      acc(1'h0, 1'h0, 21'(2 * i), 2'h3, 16'h0000);
      chk_d(got_rd, 16'(16'h1000 + i));
      chk_n(got_off, i % 4 + 1);
    end
    $display("test first region done");
    for (i = 0; i < 5; i++) begin
      cs1_sel = 3'(i);
      cs1_as = 2'(i % 4);
      wtk = i >= 2;
      acc(1'h0, 1'h1, 21'h100000 + 21'(2 * i), 2'h3, 16'(16'h2000 + i));
      chk_n(got_n, (2 << i) + i % 4 + 1);
      acc(1'h0, 1'h0, 21'h100000 + 21'(2 * i), 2'h3, 16'h0000);
      chk_d(got_rd, 16'(16'h2000 + i));
    end
    $display("test second region done");
    acc(1'h0, 1'h1, 21'h000040, 2'h3, 16'h1234);
    acc(1'h0, 1'h1, 21'h000040, 2'h1, 16'hFF55);
    acc(1'h0, 1'h0, 21'h000040, 2'h3, 16'h0000);
    chk_d(got_rd, 16'h1255);
    cs0_w16 = 1'h0;
    acc(1'h0, 1'h1, 21'h000050, 2'h3, 16'hC33C);
    acc(1'h0, 1'h0, 21'h000050, 2'h3, 16'h0000);
    chk_d(got_rd, 16'hC33C);
    cs0_w16 = 1'h1;
    $display("test byte lanes done");
    {cs0_page, cs0_two, cs0_sel, off_sel} = 7'h40;
    acc(1'h0, 1'h0, 21'h000000, 2'h3, 16'h0000);
    chk_n(got_n, 4);
    acc(1'h0, 1'h0, 21'h000002, 2'h3, 16'h0000);
    chk_n(got_n, 3);
    chk_d(got_rd, 16'h1001);
    cs0_page = 1'h0;
    $display("test page mode done");
    cs1_as = 2'h0;
    wait_len = 6'h10;
    for (i = 3; i > 1; i--) begin
      cs1_sel = 3'(i);
      acc(1'h0, 1'h0, 21'h100006, 2'h3, 16'h0000);
      chk_n(got_n, i == 3 ? 33 : 9);
      chk_d(got_rd, 16'h2003);
    end
    wait_len = 6'h00;
    $display("test wait done");
    for (i = 0; i < 2; i++) begin
      boot(2'(i), 1'h0);
      acc(1'h1, 1'h0, 21'h000000, 2'h3, 16'h0000);
      chk_d({15'h0000, got_er}, 16'h0001);
      chk_n(got_n, 1);
    end
    boot(2'h2, 1'h1);
    acc(1'h1, 1'h0, 21'h000006, 2'h3, 16'h0000);
    chk_d(got_rd, 16'h2003);
    $display("test boot refusal done");
    results;
  end
endmodule
